// *** rm_pkg.sv ***
`default_nettype none
package rm_pkg;
  // ==========================================================
  // Address phase layout
  localparam logic [6:0]  MUX_ADDR_LOW   = 7'b1001000;
  localparam logic [2:0]  LINE_ID_HEAD   = 3'b011;
  localparam logic [11:0] LINE_ID_TAIL   = 12'h001;
  localparam logic [7:0]  L2_READ_HEAD   = 8'h48;
  localparam logic [3:0]  L2_READ_TAIL   = 4'h0;
  localparam logic [3:0]  L2_CODE_BASE   = 4'h8;
  // ==========================================================
  // Command codes, first and second multiplexer
  localparam logic [7:0]  CMD_STARTSTOP_0 = 8'h0c;
  localparam logic [7:0]  CMD_STARTSTOP_1 = 8'h0e;
  localparam logic [7:0]  CMD_L1_READ_0   = 8'hd5;
  localparam logic [7:0]  CMD_L1_READ_1   = 8'hd7;
  localparam logic [7:0]  CMD_COMPL_0     = 8'h0d;
  localparam logic [7:0]  CMD_COMPL_1     = 8'h0f;
  localparam logic [7:0]  CMD_CPL_CTRL    = 8'h40;
  localparam logic [7:0]  CMD_BASE_LOAD   = 8'h41;
  localparam logic [7:0]  CMD_PROG_RESET  = 8'h42;
  // ==========================================================
  // Data values and reset values
  localparam logic [15:0] DATA_STOP      = 16'h0b00;
  localparam logic [15:0] DATA_START     = 16'h0c00;
  localparam logic [15:0] L1_DISC_STATUS = 16'h8100;
  localparam logic [15:0] BASE_RESET     = 16'h0000;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam int          L1_DISC_BIT    = 8;
  localparam int          L1_HIODIS_BIT  = 4;
  // ==========================================================
  // Host controller register offsets and bits
  localparam logic [4:0]  REG_ADDR   = 5'h00;
  localparam logic [4:0]  REG_DATA   = 5'h04;
  localparam logic [4:0]  REG_CTRL   = 5'h08;
  localparam logic [4:0]  REG_STATUS = 5'h0c;
  localparam logic [4:0]  REG_RESP   = 5'h10;
  localparam logic [4:0]  REG_LINES  = 5'h14;
  localparam int          CTRL_GO    = 0;
  localparam int          CTRL_READ  = 1;
  localparam int          CTRL_MAINT = 2;
  localparam int          CTRL_ABORT = 3;
  // ==========================================================
  // Time-out of the channel
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TIMEOUT_NS     = 1000;
  localparam int          TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** rm_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rm_link_if;
  logic        pio_stb;
  logic        pio_read;
  logic        pio_origin;
  logic [15:0] pio_addr;
  logic [15:0] pio_wdata;
  logic        term_ok;
  logic        rsp_stb;
  logic [15:0] rsp_data;
  logic        l2_req;
  logic        l1_int;
  logic        maint_int;
  modport dev (
    input  pio_stb, pio_read, pio_origin, pio_addr, pio_wdata, term_ok,
    output rsp_stb, rsp_data, l2_req, l1_int, maint_int
  );
  modport host (
    output pio_stb, pio_read, pio_origin, pio_addr, pio_wdata, term_ok,
    input  rsp_stb, rsp_data, l2_req, l1_int, maint_int
  );
endinterface
`default_nettype wire

// *** rm_mux_dev.sv ***
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rm_mux_dev #(
  parameter logic TRM_IDX = 1'b0,
  parameter logic CHAN    = 1'b0,
  parameter int   NCPL    = 2
) (
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RSTN,
  // Link to the channel
  rm_link_if.dev               LNK,
  // Coupler side
  input  wire logic [NCPL-1:0] ERR_STB,
  input  wire logic [2:0]      ERR_CODE,
  output logic      [NCPL-1:0] COUPLER_RST,
  output logic                 MUX_RESET_SEEN,
  output logic                 DISCONNECTED
);
  localparam logic [7:0] CC = {CHAN, rm_pkg::MUX_ADDR_LOW};
  function automatic logic [7:0] pick(input logic [7:0] a, input logic [7:0] b);
    pick = TRM_IDX ? b : a;
  endfunction
  function automatic logic hit(input logic [15:0] a, input logic [7:0] t);
    hit = (a[15:8] == CC) && (a[7:0] == t);
  endfunction
  // ==========================================================
  // Request decode
  logic            hio_dis;
  logic            disc;
  logic            accept;
  logic            is_gid;
  logic            is_l2rd;
  logic [3:0]      l2_k;
  logic            is_ss;
  logic            is_l1rd;
  logic            is_compl;
  logic            is_cpl;
  logic            is_base;
  logic            is_prst;
  logic            known;
  // Host operations are dropped silently while hio_dis is set so the channel times out
  assign accept   = LNK.pio_stb && (LNK.pio_origin || !hio_dis);
  assign is_gid   = LNK.pio_addr == {CHAN, rm_pkg::LINE_ID_HEAD, rm_pkg::LINE_ID_TAIL};
  assign l2_k     = LNK.pio_addr[7:4] - rm_pkg::L2_CODE_BASE;
  assign is_l2rd  = LNK.pio_addr[15:8] == rm_pkg::L2_READ_HEAD
                    && LNK.pio_addr[3:0] == rm_pkg::L2_READ_TAIL
                    && LNK.pio_addr[7:4] >= rm_pkg::L2_CODE_BASE
                    && 32'(l2_k) < NCPL;
  assign is_ss    = hit(LNK.pio_addr, pick(rm_pkg::CMD_STARTSTOP_0, rm_pkg::CMD_STARTSTOP_1));
  assign is_l1rd  = hit(LNK.pio_addr, pick(rm_pkg::CMD_L1_READ_0, rm_pkg::CMD_L1_READ_1));
  assign is_compl = hit(LNK.pio_addr, pick(rm_pkg::CMD_COMPL_0, rm_pkg::CMD_COMPL_1));
  assign is_cpl   = hit(LNK.pio_addr, rm_pkg::CMD_CPL_CTRL);
  assign is_base  = hit(LNK.pio_addr, rm_pkg::CMD_BASE_LOAD);
  assign is_prst  = hit(LNK.pio_addr, rm_pkg::CMD_PROG_RESET) && !LNK.pio_read;
  assign known    = is_gid || is_l2rd || is_ss || is_l1rd || is_compl || is_cpl || is_base || is_prst;
  logic stop_cmd;
  logic start_cmd;
  logic l1rd_disc;
  assign stop_cmd  = accept && is_ss && LNK.pio_origin && LNK.pio_wdata == rm_pkg::DATA_STOP;
  assign start_cmd = accept && is_ss && LNK.pio_origin && LNK.pio_wdata == rm_pkg::DATA_START;
  assign l1rd_disc = accept && is_l1rd && LNK.pio_read && !LNK.pio_origin && disc;
  // Programmed reset lands one cycle after its command was taken
  logic prst;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      prst <= 1'b0;
    end else begin
      prst <= accept && is_prst;
    end
  end
  logic soft_rst;
  assign soft_rst = !RSTN || prst;
  // ==========================================================
  // Disconnect and host disable latches, untouched by programmed reset
  always_ff @(posedge CLK) begin
    DISCONNECTED <= RSTN && disc;
    if (!RSTN) begin
      disc    <= 1'b0;
      hio_dis <= 1'b0;
    end else if (stop_cmd) begin
      disc <= 1'b1;
    end else if (start_cmd) begin
      disc    <= 1'b0;
      hio_dis <= 1'b0;
    end else if (l1rd_disc) begin
      hio_dis <= 1'b1;
    end
  end
  // ==========================================================
  // Coupler reset bits and multiplexer reset bit
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      COUPLER_RST <= '1;
    end else if (accept && is_cpl && !LNK.pio_read) begin
      COUPLER_RST <= LNK.pio_wdata[NCPL-1:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      MUX_RESET_SEEN <= 1'b1;
    end else if (accept && is_cpl && !LNK.pio_read) begin
      MUX_RESET_SEEN <= 1'b0;
    end
  end
  // ==========================================================
  // Line ID base
  logic [15:0] base;
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      base <= rm_pkg::BASE_RESET;
    end else if (accept && is_base && !LNK.pio_read) begin
      base <= LNK.pio_wdata;
    end
  end
  // ==========================================================
  // Level 2 error status per coupler and pending requests
  logic [2:0]      l2_stat [NCPL];
  logic [NCPL-1:0] raised;
  logic [NCPL-1:0] clr_stat;
  logic [NCPL-1:0] clr_raise;
  logic            rr;
  logic            gid_pend;
  logic            l2_pend;
  logic [15:0]     pend_k;
  logic [15:0]     gid_cpl;
  // Scanner: first raised coupler from the pointer onward
  logic [15:0] win;
  logic        any;
  always_comb begin
    win = 16'h0000;
    any = 1'b0;
    for (int j = NCPL - 1; j >= 0; j--) begin
      if (raised[(32'(rr) + j) % NCPL]) begin
        win = 16'((32'(rr) + j) % NCPL);
        any = 1'b1;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCPL; g++) begin : g_cpl
      assign clr_stat[g]  = l2_pend && LNK.term_ok && pend_k == 16'(g);
      assign clr_raise[g] = gid_pend && LNK.term_ok && gid_cpl == 16'(g);
      always_ff @(posedge CLK) begin
        if (soft_rst) begin
          l2_stat[g] <= 3'b000;
        end else if (ERR_STB[g] && (l2_stat[g] == 3'b000 || clr_stat[g])) begin
          l2_stat[g] <= ERR_CODE;
        end else if (clr_stat[g]) begin
          l2_stat[g] <= 3'b000;
        end
      end
      // Only errors raise own interrupts; set wins over clear
      always_ff @(posedge CLK) begin
        if (soft_rst) begin
          raised[g] <= 1'b0;
        end else if (ERR_STB[g] && (l2_stat[g] == 3'b000 || clr_stat[g]) && !disc) begin
          raised[g] <= 1'b1;
        end else if (clr_raise[g]) begin
          raised[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      rr <= 1'b0;
    end else if (gid_pend && LNK.term_ok) begin
      rr <= !gid_cpl[0];
    end
  end
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      LNK.l2_req <= 1'b0;
    end else begin
      LNK.l2_req <= (|(raised & ~clr_raise)) && !disc;
    end
  end
  // ==========================================================
  // Level 1 interrupt, maintenance interrupt, completion value
  logic [15:0] compl;
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      LNK.l1_int <= 1'b0;
    end else if (stop_cmd) begin
      LNK.l1_int <= 1'b1;
    end else if (accept && is_l1rd && LNK.pio_read) begin
      LNK.l1_int <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      LNK.maint_int <= 1'b0;
      compl         <= rm_pkg::ZERO16;
    end else if (l1rd_disc) begin
      LNK.maint_int <= 1'b1;
      compl         <= rm_pkg::DATA_STOP;
    end else if (disc && |ERR_STB) begin
      LNK.maint_int <= 1'b1;
    end else if (accept && is_compl && LNK.pio_read && LNK.pio_origin) begin
      LNK.maint_int <= 1'b0;
    end
  end
  // ==========================================================
  // Answer, one cycle after the request
  logic [15:0] l1_word;
  always_comb begin
    l1_word                        = disc ? rm_pkg::L1_DISC_STATUS : rm_pkg::ZERO16;
    l1_word[rm_pkg::L1_DISC_BIT]   = disc;
    // Disable bit shows the latch as this read leaves it
    l1_word[rm_pkg::L1_HIODIS_BIT] = hio_dis || l1rd_disc;
  end
  always_ff @(posedge CLK) begin
    if (soft_rst) begin
      LNK.rsp_stb  <= 1'b0;
      LNK.rsp_data <= rm_pkg::ZERO16;
      gid_pend     <= 1'b0;
      l2_pend      <= 1'b0;
      gid_cpl      <= 16'h0000;
      pend_k       <= 16'h0000;
    end else begin
      LNK.rsp_stb  <= accept && known && !(is_gid && !any);
      LNK.rsp_data <= rm_pkg::ZERO16;
      gid_pend     <= accept && is_gid && any && LNK.pio_read;
      l2_pend      <= accept && is_l2rd && LNK.pio_read;
      gid_cpl      <= win;
      pend_k       <= {12'h000, l2_k};
      if (accept && LNK.pio_read && (any || !is_gid)) begin
        if (is_gid) begin
          LNK.rsp_data <= base + {win[14:0], 1'b1};
        end else if (is_l2rd) begin
          LNK.rsp_data <= {5'h00, l2_stat[32'(l2_k)], 8'h00};
        end else if (is_l1rd) begin
          LNK.rsp_data <= l1_word;
        end else if (is_compl) begin
          LNK.rsp_data <= compl;
        end else if (is_cpl) begin
          LNK.rsp_data <= 16'(COUPLER_RST);
        end else if (is_base) begin
          LNK.rsp_data <= base;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rm_host_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module rm_host_ctl #(
  parameter int TIMEOUT = rm_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Link to the multiplexer
  rm_link_if.host          LNK,
  // Register port
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA
);
  typedef enum logic [1:0] {RM_IDLE, RM_WAIT} rm_state_t;
  rm_state_t   state;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [3:0]  ctrl;
  logic [15:0] resp;
  logic        done;
  logic        tout;
  logic [15:0] cnt;
  logic        go;

  assign go = REG_WR && REG_ADDR == rm_pkg::REG_CTRL && REG_WDATA[rm_pkg::CTRL_GO] && state == RM_IDLE;

  // ==========================================================
  // Order registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      addr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      ctrl     <= 4'h0;
    end else if (REG_WR) begin
      if (REG_ADDR == rm_pkg::REG_ADDR) begin
        addr_reg <= REG_WDATA;
      end
      if (REG_ADDR == rm_pkg::REG_DATA) begin
        data_reg <= REG_WDATA;
      end
      if (REG_ADDR == rm_pkg::REG_CTRL) begin
        ctrl <= REG_WDATA[3:0];
      end
    end
  end

  // ==========================================================
  // Operation sequencer with channel time-out
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state         <= RM_IDLE;
      LNK.pio_stb   <= 1'b0;
      LNK.pio_read  <= 1'b0;
      LNK.pio_origin <= 1'b0;
      LNK.pio_addr  <= 16'h0000;
      LNK.pio_wdata <= 16'h0000;
      cnt           <= 16'h0000;
      done          <= 1'b0;
      tout          <= 1'b0;
      resp          <= 16'h0000;
    end else begin
      LNK.pio_stb <= 1'b0;
      case (state)
        RM_IDLE: begin
          if (go) begin
            LNK.pio_stb    <= 1'b1;
            LNK.pio_read   <= REG_WDATA[rm_pkg::CTRL_READ];
            LNK.pio_origin <= REG_WDATA[rm_pkg::CTRL_MAINT];
            LNK.pio_addr   <= addr_reg;
            LNK.pio_wdata  <= data_reg;
            cnt            <= 16'h0000;
            done           <= 1'b0;
            tout           <= 1'b0;
            state          <= RM_WAIT;
          end
        end
        RM_WAIT: begin
          cnt <= cnt + 16'h0001;
          if (LNK.rsp_stb) begin
            resp  <= LNK.rsp_data;
            done  <= 1'b1;
            state <= RM_IDLE;
          end else if (32'(cnt) >= TIMEOUT) begin
            tout  <= 1'b1;
            done  <= 1'b1;
            state <= RM_IDLE;
          end
        end
        default: state <= RM_IDLE;
      endcase
    end
  end

  // Abnormal termination is forced by the abort bit
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LNK.term_ok <= 1'b1;
    end else begin
      LNK.term_ok <= !ctrl[rm_pkg::CTRL_ABORT];
    end
  end

  // ==========================================================
  // Read port, data in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        rm_pkg::REG_ADDR:   REG_RDATA <= addr_reg;
        rm_pkg::REG_DATA:   REG_RDATA <= data_reg;
        rm_pkg::REG_CTRL:   REG_RDATA <= {12'h000, ctrl};
        rm_pkg::REG_STATUS: REG_RDATA <= {13'h0000, tout, done, state == RM_WAIT};
        rm_pkg::REG_RESP:   REG_RDATA <= resp;
        rm_pkg::REG_LINES:  REG_RDATA <= {13'h0000, LNK.maint_int, LNK.l1_int, LNK.l2_req};
        default:            REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** rm_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rm_link_sva (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // Link signals
  input wire logic        pio_stb,
  input wire logic        pio_read,
  input wire logic        pio_origin,
  input wire logic [15:0] pio_addr,
  input wire logic [15:0] pio_wdata,
  input wire logic        term_ok,
  input wire logic        rsp_stb,
  input wire logic [15:0] rsp_data,
  input wire logic        l2_req,
  input wire logic        l1_int,
  input wire logic        maint_int
);
  // ==========================================================
  // Shadow of the two latches, rebuilt from link traffic only
  logic hdis;
  logic disc;
  logic host_l1;
  logic stop_w;
  logic start_w;
  logic host_lid;
  assign host_l1  = pio_stb && !pio_origin && pio_read && pio_addr == 16'h48d5;
  assign stop_w   = pio_stb && pio_origin && !pio_read && pio_addr == 16'h480c && pio_wdata == 16'h0b00;
  assign start_w  = pio_stb && pio_origin && !pio_read && pio_addr == 16'h480c && pio_wdata == 16'h0c00;
  assign host_lid = pio_stb && !pio_origin && pio_read && pio_addr == 16'h3001 && !hdis;
  always_ff @(posedge CLK) begin
    if (!RSTN || start_w) begin
      disc <= 1'b0;
    end else if (stop_w) begin
      disc <= 1'b1;
    end
  end
  // Only a level 1 read taken while disconnected arms the refusal
  always_ff @(posedge CLK) begin
    if (!RSTN || start_w) begin
      hdis <= 1'b0;
    end else if (host_l1 && disc && !hdis) begin
      hdis <= 1'b1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_stop_raises_l1: assert property (stop_w |-> ##[1:2] l1_int)
    else $error("stop did not raise level 1");
  a_l1_read_disables: assert property (host_l1 && disc && !hdis |-> ##[1:2] (maint_int && !l1_int))
    else $error("level 1 read did not hand over to maintenance");
  a_host_refused: assert property (pio_stb && !pio_origin && hdis |=> !rsp_stb ##1 !rsp_stb)
    else $error("host operation answered while disabled");
  a_maint_served: assert property (pio_stb && pio_origin && pio_read && pio_addr == 16'h480d |=> rsp_stb)
    else $error("maintenance read not answered");
  a_lid_type_b: assert property (host_lid && l2_req |=> rsp_stb && rsp_data[0])
    else $error("line id answer not type B");
  a_l2_drop: assert property (host_lid && l2_req ##1 rsp_stb && term_ok |=> !l2_req)
    else $error("level 2 kept after normal line id");
  a_l2_kept_abort: assert property (host_lid && l2_req ##1 rsp_stb && !term_ok |=> l2_req)
    else $error("level 2 dropped after aborted line id");
  a_no_l2_disc: assert property (disc |=> !l2_req)
    else $error("level 2 raised while disconnected");
  a_reset_quiet: assert property ($rose(RSTN) |-> !l2_req && !l1_int && !maint_int && !rsp_stb)
    else $error("requests active after reset");
endmodule
`default_nettype wire

// *** ring_multiplexer_intr_disc_reset_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_multiplexer_intr_disc_reset_test;
  // ==========================================================
  // Signals
  logic        clk;
  logic        rstn;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [1:0]  err_stb;
  logic [2:0]  err_code;
  logic [1:0]  cpl_rst;
  logic        rst_seen;
  logic        disc;
  logic [15:0] rsp;
  logic [15:0] st;
  int          n_mismatch;
  int          checks;
  rm_link_if lnk ();
  rm_mux_dev #(.TRM_IDX(1'b0), .CHAN(1'b0), .NCPL(2)) i_rm_mux_dev (.CLK(clk), .RSTN(rstn), .LNK(lnk.dev),
    .ERR_STB(err_stb), .ERR_CODE(err_code), .COUPLER_RST(cpl_rst), .MUX_RESET_SEEN(rst_seen), .DISCONNECTED(disc));
  // Short time-out keeps refused operations cheap
  rm_host_ctl #(.TIMEOUT(8)) i_rm_host_ctl (.CLK(clk), .RSTN(rstn), .LNK(lnk.host), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  rm_link_sva i_rm_link_sva (.CLK(clk), .RSTN(rstn), .pio_stb(lnk.pio_stb), .pio_read(lnk.pio_read),
    .pio_origin(lnk.pio_origin), .pio_addr(lnk.pio_addr), .pio_wdata(lnk.pio_wdata), .term_ok(lnk.term_ok),
    .rsp_stb(lnk.rsp_stb), .rsp_data(lnk.rsp_data), .l2_req(lnk.l2_req), .l1_int(lnk.l1_int),
    .maint_int(lnk.maint_int));
  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // One link operation through the controller; leaves status in st, answer in rsp
  task automatic programmed_io_op(input logic [15:0] a, input logic [15:0] d, input logic rd, input logic mnt);
    int n;
    reg_write(rm_pkg::REG_ADDR, a);
    reg_write(rm_pkg::REG_DATA, d);
    reg_write(rm_pkg::REG_CTRL, {13'h0000, mnt, rd, 1'b1});
    n  = 0;
    st = 16'h0001;
    while (st[0] !== 1'b0 && n < 40) begin
      reg_read(rm_pkg::REG_STATUS, st);
      n++;
    end
    if (st[0] !== 1'b0) begin
      n_mismatch++;
      $display("BAD %0t operation never finished", $time);
    end
    reg_read(rm_pkg::REG_RESP, rsp);
  endtask
  task automatic lines(input logic [2:0] exp, input string what);
    reg_read(rm_pkg::REG_LINES, st);
    check(st & 16'h0007, {13'h0000, exp}, what);
  endtask
  task automatic err(input int c, input logic [2:0] code);
    @(posedge clk);
    err_stb[c] <= 1'b1;
    err_code   <= code;
    @(posedge clk);
    err_stb    <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0;
    checks     = 0;
    rstn       = 1'b0;
    reg_addr   = 5'h00;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    err_stb    = 2'b00;
    err_code   = 3'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check({14'h0000, cpl_rst}, 16'h0003, "coupler leads at reset");
    check({15'h0000, rst_seen}, 16'h0001, "reset bit");
    check({15'h0000, disc}, 16'h0000, "disconnect at reset");
    lines(3'b000, "lines at reset");
    programmed_io_op(16'h4841, 16'h0100, 1'b0, 1'b0);
    programmed_io_op(16'h4840, 16'h0000, 1'b0, 1'b0);
    check({13'h0000, cpl_rst, rst_seen}, 16'h0000, "coupler leads released");
    lines(3'b000, "no interrupt for normal work");
    err(1, 3'h2);
    lines(3'b001, "level 2 on error");
    // Get line ID with go, read and abort bits: answered, but not a normal end
    reg_write(rm_pkg::REG_ADDR, 16'h3001);
    reg_write(rm_pkg::REG_CTRL, 16'h000b);
    repeat (4) @(posedge clk);
    lines(3'b001, "level 2 kept on abort");
    programmed_io_op(16'h3001, 16'h0000, 1'b1, 1'b0);
    check(rsp, 16'h0103, "type B line id");
    lines(3'b000, "level 2 dropped");
    programmed_io_op(16'h4890, 16'h0000, 1'b1, 1'b0);
    check(rsp & 16'h0700, 16'h0200, "level 2 status");
    programmed_io_op(16'h4840, 16'h0001, 1'b0, 1'b0);
    check({14'h0000, cpl_rst}, 16'h0001, "selective coupler reset");
    programmed_io_op(16'h480c, 16'h0b00, 1'b0, 1'b1);
    check({15'h0000, disc}, 16'h0001, "stop disconnects");
    lines(3'b010, "level 1 after stop");
    programmed_io_op(16'h48d5, 16'h0000, 1'b1, 1'b0);
    check(rsp & 16'h8180, 16'h8100, "level 1 status");
    lines(3'b100, "maintenance interrupt");
    programmed_io_op(16'h4841, 16'h1234, 1'b0, 1'b0);
    check(st & 16'h0006, 16'h0006, "host times out");
    programmed_io_op(16'h480d, 16'h0000, 1'b1, 1'b1);
    check(rsp, 16'h0b00, "command completion");
    lines(3'b000, "completion clears");
    err(0, 3'h1);
    lines(3'b100, "error to maintenance");
    programmed_io_op(16'h4880, 16'h0000, 1'b1, 1'b1);
    check(rsp & 16'h0700, 16'h0100, "maintenance status read");
    programmed_io_op(16'h480d, 16'h0000, 1'b1, 1'b1);
    programmed_io_op(16'h4842, 16'h0000, 1'b0, 1'b1);
    check({13'h0000, cpl_rst, disc}, 16'h0003, "programmed reset keeps");
    check({15'h0000, rst_seen}, 16'h0001, "programmed reset bit");
    programmed_io_op(16'h480c, 16'h0c00, 1'b0, 1'b1);
    check({15'h0000, disc}, 16'h0000, "start reconnects");
    err(0, 3'h3);
    lines(3'b001, "level 2 after reconnect");
    programmed_io_op(16'h3001, 16'h0000, 1'b1, 1'b0);
    check(rsp, 16'h0001, "base cleared");
    programmed_io_op(16'h480c, 16'h0b00, 1'b0, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check({13'h0000, cpl_rst, disc}, 16'h0006, "hardware reset");
    lines(3'b000, "lines after reset");
    test_done();
  end
endmodule
`default_nettype wire
